// File: inc/csh_cfg.svh
// constants for the configuration status handshake block
`ifndef CSH_CFG_SVH
`define CSH_CFG_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CSH_OFF_CTRL 8'h00
`define CSH_OFF_DATA 8'h04
`define CSH_OFF_CHECK 8'h08
`define CSH_OFF_STAT 8'h0c
`define CSH_OFF_ISTAT 8'h10
`define CSH_OFF_IMASK 8'h14
`define CSH_OFF_RADDR 8'h18
`define CSH_OFF_RDATA 8'h1c
// ------------------------------------------------------------
// control bits
// ------------------------------------------------------------
`define CSH_CTRL_START 0
`define CSH_CTRL_FINISH 1
`define CSH_CTRL_REINIT 2
`define CSH_CTRL_SCAN 3
// ------------------------------------------------------------
// event bits of the interrupt status and mask
// ------------------------------------------------------------
`define CSH_EV_READY 0
`define CSH_EV_LOADED 1
`define CSH_EV_CHECK 2
`define CSH_EV_USER 3
`define CSH_EV_W 4
// ------------------------------------------------------------
// boot source codes and reset values
// ------------------------------------------------------------
`define CSH_MODE_MIN 4'h1
`define CSH_MODE_MAX 4'hd
`define CSH_MODE_CPU_LO 4'h3
`define CSH_MODE_CPU_HI 4'h7
`define CSH_RST_WORD 32'h0000_0000
`define CSH_RST_EV 4'h0
`define CSH_RST_MODE 4'h0
`endif

// File: inc/csh_pkg.sv
// types shared by the configuration status handshake block
package csh_pkg;
   typedef enum logic [2:0] {
      st_clear,
      st_await,
      st_load,
      st_wait_done,
      st_user,
      st_error
   } csh_state_t;
endpackage : csh_pkg

// File: verilog/csh_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module csh_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // asynchronous in, synchronous out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : csh_sync
`default_nettype wire

// File: verilog/csh_configuration_memory.sv
// configuration memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module csh_configuration_memory #(
   parameter int DW = 32,
   parameter int AW = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // read port
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // array has no reset: the owner clears it word by word
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule : csh_configuration_memory
`default_nettype wire

// File: verilog/csh_top.sv
// configuration unit: boot source, open-drain status pins, load sequence
// Function
// - The unit samples the 4-bit boot source selection to choose CPU or flash loading.
// - The ready pin is released only after startup and memory clear, awaiting commands.
// - Once released, the ready pin stays released until reset, reinit, a check error or a data overflow during load.
// - The load-complete pin is released only after an error-free load.
// - Once released, the load-complete pin stays released until reset or reinit.
// - On a load error the load-complete pin stays driven low.
// - The unit proceeds past loading only when it reads the load-complete line high.
// - The asynchronous low reset clears the configuration memory and all unit logic.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "csh_cfg.svh"
module csh_top #(
   parameter int DEPTH = 64,
   parameter int AW = $clog2(DEPTH)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // boot source pins
   input wire logic [3:0] boot_source_select,
   // open-drain ready pin
   input wire logic config_ready_flag_i,
   output logic config_ready_flag_o,
   output logic config_ready_flag_oe,
   // open-drain load-complete pin
   input wire logic load_complete_flag_i,
   output logic load_complete_flag_o,
   output logic load_complete_flag_oe,
   // interrupt
   output logic irq
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic mode_valid(input logic [3:0] m);
      mode_valid = (m >= `CSH_MODE_MIN) && (m <= `CSH_MODE_MAX);
   endfunction : mode_valid
   function automatic logic mode_cpu(input logic [3:0] m);
      mode_cpu = (m >= `CSH_MODE_CPU_LO) && (m <= `CSH_MODE_CPU_HI);
   endfunction : mode_cpu
   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == `CSH_OFF_CTRL) || (a == `CSH_OFF_DATA) ||
                    (a == `CSH_OFF_CHECK) || (a == `CSH_OFF_STAT) ||
                    (a == `CSH_OFF_ISTAT) || (a == `CSH_OFF_IMASK) ||
                    (a == `CSH_OFF_RADDR) || (a == `CSH_OFF_RDATA);
   endfunction : addr_mapped
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [5:0] pins_s;
   logic [3:0] mode_s;
   logic done_line_s, ready_line_s;
   csh_sync #(.W(6)) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d({boot_source_select, load_complete_flag_i, config_ready_flag_i}),
      .q(pins_s)
   );
   assign mode_s = pins_s[5:2];
   assign done_line_s = pins_s[1];
   assign ready_line_s = pins_s[0];

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic pready_r;
   logic setup, wr, rd, ctrl_wr, data_wr, istat_rd;
   logic start_p, finish_p, reinit_p;
   assign setup = psel & ~penable;
   assign wr = psel & penable & pready_r & pwrite;
   assign rd = psel & penable & pready_r & ~pwrite;
   assign ctrl_wr = wr && (paddr == `CSH_OFF_CTRL);
   assign start_p = ctrl_wr && pwdata[`CSH_CTRL_START];
   assign finish_p = ctrl_wr && pwdata[`CSH_CTRL_FINISH];
   assign reinit_p = ctrl_wr && pwdata[`CSH_CTRL_REINIT];
   assign data_wr = wr && (paddr == `CSH_OFF_DATA);
   assign istat_rd = rd && (paddr == `CSH_OFF_ISTAT);

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   logic scan_en_r;
   logic [31:0] check_r;
   logic [`CSH_EV_W-1:0] imask_r;
   logic [AW-1:0] raddr_r;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scan_en_r <= 1'b0;
         check_r <= `CSH_RST_WORD;
         imask_r <= `CSH_RST_EV;
         raddr_r <= '0;
      end else begin
         if (ctrl_wr) begin
            scan_en_r <= pwdata[`CSH_CTRL_SCAN];
         end
         if (wr && (paddr == `CSH_OFF_CHECK)) begin
            check_r <= pwdata;
         end
         if (wr && (paddr == `CSH_OFF_IMASK)) begin
            imask_r <= pwdata[`CSH_EV_W-1:0];
         end
         if (wr && (paddr == `CSH_OFF_RADDR)) begin
            raddr_r <= pwdata[AW-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // load sequencer
   // ------------------------------------------------------------
   csh_pkg::csh_state_t state_r;
   logic [AW-1:0] clr_cnt_r;
   logic [AW:0] wcnt_r;
   logic [31:0] sum_r;
   logic [3:0] mode_r;
   logic clr_last, fin_ok, fin_bad, overflow, load_ok;
   assign clr_last = (clr_cnt_r == AW'(DEPTH - 1));
   assign overflow = data_wr && (wcnt_r == (AW + 1)'(DEPTH));
   assign fin_ok = (state_r == csh_pkg::st_load) && finish_p && (sum_r == check_r);
   assign fin_bad = (state_r == csh_pkg::st_load) &&
                    ((finish_p && (sum_r != check_r)) || overflow);
   // scan loading ignores the boot source entirely
   assign load_ok = mode_valid(mode_r) || scan_en_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= csh_pkg::st_clear;
         clr_cnt_r <= '0;
         wcnt_r <= '0;
         sum_r <= `CSH_RST_WORD;
         mode_r <= `CSH_RST_MODE;
      end else if (reinit_p) begin
         state_r <= csh_pkg::st_clear;
         clr_cnt_r <= '0;
      end else begin
         unique case (state_r)
            csh_pkg::st_clear: begin
               clr_cnt_r <= clr_cnt_r + 1'b1;
               if (clr_last) begin
                  mode_r <= mode_s;
                  state_r <= csh_pkg::st_await;
               end
            end
            csh_pkg::st_await: begin
               if (start_p && load_ok) begin
                  wcnt_r <= '0;
                  sum_r <= `CSH_RST_WORD;
                  state_r <= csh_pkg::st_load;
               end
            end
            csh_pkg::st_load: begin
               if (fin_bad) begin
                  state_r <= csh_pkg::st_error;
               end else if (fin_ok) begin
                  state_r <= csh_pkg::st_wait_done;
               end else if (data_wr) begin
                  wcnt_r <= wcnt_r + 1'b1;
                  sum_r <= sum_r + pwdata;
               end
            end
            csh_pkg::st_wait_done: begin
               // board may hold the line low to line devices up
               if (done_line_s) begin
                  state_r <= csh_pkg::st_user;
               end
            end
            csh_pkg::st_user, csh_pkg::st_error: state_r <= state_r;
            default: state_r <= csh_pkg::st_error;
         endcase
      end
   end

   // ------------------------------------------------------------
   // configuration memory
   // ------------------------------------------------------------
   logic mem_we, clearing;
   logic [AW-1:0] mem_waddr;
   logic [31:0] mem_wdata, mem_rdata;
   assign clearing = (state_r == csh_pkg::st_clear);
   assign mem_we = clearing || ((state_r == csh_pkg::st_load) && data_wr && !overflow);
   assign mem_waddr = clearing ? clr_cnt_r : wcnt_r[AW-1:0];
   assign mem_wdata = clearing ? `CSH_RST_WORD : pwdata;
   csh_configuration_memory #(.DW(32), .AW(AW)) u_configuration_memory (
      .clk(clk),
      .rst_b(rst_b),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(raddr_r),
      .rdata(mem_rdata)
   );

   // ------------------------------------------------------------
   // open-drain status pins
   // ------------------------------------------------------------
   // enables high while the pin is pulled low; released means high
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         config_ready_flag_oe <= 1'b1;
         config_ready_flag_o <= 1'b0;
      end else begin
         config_ready_flag_o <= 1'b0;
         if (reinit_p || fin_bad) begin
            config_ready_flag_oe <= 1'b1;
         end else if (clearing && clr_last) begin
            config_ready_flag_oe <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         load_complete_flag_oe <= 1'b1;
         load_complete_flag_o <= 1'b0;
      end else begin
         load_complete_flag_o <= 1'b0;
         if (reinit_p) begin
            load_complete_flag_oe <= 1'b1;
         end else if (fin_ok) begin
            load_complete_flag_oe <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt status, read to clear
   // ------------------------------------------------------------
   logic [`CSH_EV_W-1:0] istat_r, ev;
   always_comb begin
      ev = '0;
      ev[`CSH_EV_READY] = clearing && clr_last && !reinit_p;
      ev[`CSH_EV_LOADED] = fin_ok && !reinit_p;
      ev[`CSH_EV_CHECK] = fin_bad && !reinit_p;
      ev[`CSH_EV_USER] = (state_r == csh_pkg::st_wait_done) && done_line_s && !reinit_p;
   end
   // a new event in the clearing read cycle survives
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         istat_r <= `CSH_RST_EV;
      end else begin
         istat_r <= (istat_rd ? '0 : istat_r) | ev;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |(istat_r & imask_r);
      end
   end

   // ------------------------------------------------------------
   // apb answer: one access cycle, no waits
   // ------------------------------------------------------------
   logic [31:0] stat_word;
   assign stat_word = {(16 - AW - 1)'(0), wcnt_r, 1'b0, done_line_s, ready_line_s,
                       !load_complete_flag_oe, !config_ready_flag_oe, scan_en_r,
                       mode_cpu(mode_r), mode_valid(mode_r), mode_r, 1'b0, state_r};
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready_r <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `CSH_RST_WORD;
      end else begin
         pready_r <= setup;
         pready <= setup;
         pslverr <= setup && !addr_mapped(paddr);
         if (setup && !pwrite) begin
            unique case (paddr)
               `CSH_OFF_CTRL: prdata <= {28'h0, scan_en_r, 3'h0};
               `CSH_OFF_CHECK: prdata <= check_r;
               `CSH_OFF_STAT: prdata <= stat_word;
               `CSH_OFF_ISTAT: prdata <= {28'h0, istat_r};
               `CSH_OFF_IMASK: prdata <= {28'h0, imask_r};
               `CSH_OFF_RADDR: prdata <= 32'(raddr_r);
               `CSH_OFF_RDATA: prdata <= mem_rdata;
               default: prdata <= `CSH_RST_WORD;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_mode_latch: assert property (
      $past(state_r) == csh_pkg::st_clear && state_r == csh_pkg::st_await
      |-> mode_r == $past(mode_s))
      else $error("boot source not latched at end of clear");
   a_ready_release: assert property (
      $fell(config_ready_flag_oe) |-> $past(clearing && clr_last))
      else $error("ready pin released outside end of clear");
   a_ready_holds: assert property (
      !config_ready_flag_oe && !reinit_p && !fin_bad |=> !config_ready_flag_oe)
      else $error("ready pin pulled low without cause");
   a_done_release: assert property (
      $fell(load_complete_flag_oe) |-> $past(fin_ok) && $past(state_r) == csh_pkg::st_load)
      else $error("load-complete released without good load");
   a_done_holds: assert property (
      !load_complete_flag_oe && !reinit_p |=> !load_complete_flag_oe)
      else $error("load-complete pulled low without reinit");
   a_error_low: assert property (
      state_r == csh_pkg::st_error |-> load_complete_flag_oe && config_ready_flag_oe)
      else $error("pins released in error state");
   a_user_gate: assert property (
      state_r == csh_pkg::st_wait_done && !done_line_s && !reinit_p
      |=> state_r == csh_pkg::st_wait_done)
      else $error("left wait without high load-complete line");
   a_clear_walk: assert property (
      $rose(clearing) |-> mem_we && clr_cnt_r == '0 ##1 clearing [*2])
      else $error("memory clear walk did not start from zero");
   a_scan_path: assert property (
      state_r == csh_pkg::st_await && scan_en_r && start_p && !reinit_p
      |=> state_r == csh_pkg::st_load)
      else $error("scan load refused");
endmodule : csh_top
`default_nettype wire

// File: testbench/csh_board.sv
// board model: pull-ups on both open-drain lines and a hold-low switch
`timescale 1ns/1ps
`default_nettype none
module csh_board (
   // pins from the unit
   input wire logic ready_o,
   input wire logic ready_oe,
   input wire logic done_o,
   input wire logic done_oe,
   // bench command: hold the shared done line low
   input wire logic hold_low,
   // resolved lines
   output logic ready_line,
   output logic done_line
);
   // ----------------------------------------
   // wired lines with board pull-ups
   // ----------------------------------------
   assign ready_line = ready_oe ? ready_o : 1'b1;
   // pull-up wins only when neither the unit nor the board pulls low
   assign done_line = (done_oe ? done_o : 1'b1) & ~hold_low;
endmodule : csh_board
`default_nettype wire

// File: testbench/csh_top_test.sv
// self-checking bench for the configuration status handshake block
`timescale 1ns/1ps
`default_nettype none
`include "csh_cfg.svh"
module csh_top_test;
   localparam int DEP = 8;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, hold_low;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, sum, seed;
   logic [3:0] boot_source_select;
   logic r_o, r_oe, d_o, d_oe, rl, dl, err;
   logic [31:0] words[$];
   logic [5:0] be;
   int n_fail, samples_checked;

   csh_top #(.DEPTH(DEP)) uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .boot_source_select(boot_source_select),
      .config_ready_flag_i(rl), .config_ready_flag_o(r_o), .config_ready_flag_oe(r_oe),
      .load_complete_flag_i(dl), .load_complete_flag_o(d_o), .load_complete_flag_oe(d_oe),
      .irq(irq));
   csh_board board (.ready_o(r_o), .ready_oe(r_oe), .done_o(d_o), .done_oe(d_oe),
      .hold_low(hold_low), .ready_line(rl), .done_line(dl));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   // model of the boot code decode: {cpu, valid, code}
   function automatic logic [5:0] boot_exp(input logic [3:0] c);
      return {c >= 4'h3 && c <= 4'h7, c >= 4'h1 && c <= 4'hd, c};
   endfunction : boot_exp

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one apb transfer; holds the request until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // pready, prdata and pslverr are taken at the rising edge that ends the access
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      chk("pready", 1, n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_ready();
      int n;
      n = 0;
      while (r_oe !== 1'b0 && n < 4 * DEP + 20) begin
         @(negedge clk);
         n++;
      end
      chk("ready_oe released", 0, r_oe);
   endtask : wait_ready

   task automatic reinit(input logic [3:0] c);
      boot_source_select <= c;
      repeat (3) @(posedge clk);
      apb(1, `CSH_OFF_CTRL, 32'h4);
      repeat (2) @(negedge clk);
      chk("ready_oe after reinit", 1, r_oe);
      wait_ready();
   endtask : reinit

   // load n words; bad adds an error to the expected sum
   task automatic load(input int n, input logic bad);
      words.delete();
      sum = 0;
      for (int i = 0; i < n; i++) begin
         words.push_back(xs());
         sum = sum + words[i];
      end
      apb(1, `CSH_OFF_CHECK, sum + 32'(bad));
      apb(1, `CSH_OFF_CTRL, 32'h1);
      foreach (words[i]) apb(1, `CSH_OFF_DATA, words[i]);
      apb(1, `CSH_OFF_CTRL, 32'h2);
      repeat (2) @(negedge clk);
   endtask : load

   task automatic final_report();
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report

   // ----------------------------------------
   // clock and watchdog
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      #300000;
      n_fail++;
      final_report();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      n_fail = 0;
      samples_checked = 0;
      seed = 32'h1fd7;
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      boot_source_select = 4'h4;
      hold_low = 1'b0;
      repeat (3) @(posedge clk);
      chk("ready_oe in reset", 1, r_oe);
      chk("done_oe in reset", 1, d_oe);
      rst_b <= 1'b1;
      wait_ready();
      apb(1, `CSH_OFF_IMASK, 32'h1);
      repeat (2) @(negedge clk);
      chk("irq unmasked", 1, irq);
      apb(1, `CSH_OFF_IMASK, 32'h0);
      repeat (2) @(negedge clk);
      chk("irq masked", 0, irq);
      apb(0, `CSH_OFF_ISTAT, 0);
      chk("istat ready", 1, rd[0]);
      apb(0, `CSH_OFF_ISTAT, 0);
      chk("istat cleared", 0, rd[0]);
      apb(0, 8'h40, 0);
      chk("unmapped err", 1, err);
      chk("unmapped data", 0, rd);
      $display("test startup done");

      for (int c = 0; c < 16; c++) begin
         reinit(c[3:0]);
         apb(1, `CSH_OFF_CTRL, 32'h1);
         apb(0, `CSH_OFF_STAT, 0);
         be = boot_exp(c[3:0]);
         chk("boot decode", {26'h0, be}, {26'h0, rd[9:4]});
         chk("start taken", be[4] ? 2 : 1, rd[2:0]);
      end
      apb(1, `CSH_OFF_CTRL, 32'h8);
      apb(1, `CSH_OFF_CTRL, 32'h9);
      apb(0, `CSH_OFF_STAT, 0);
      chk("scan start", 2, rd[2:0]);
      $display("test boot codes done");

      reinit(4'h4);
      hold_low <= 1'b1;
      load(3, 1'b0);
      chk("done_oe good", 0, d_oe);
      repeat (10) @(negedge clk);
      apb(0, `CSH_OFF_STAT, 0);
      chk("held in wait", 3, rd[2:0]);
      hold_low <= 1'b0;
      repeat (6) @(posedge clk);
      apb(0, `CSH_OFF_STAT, 0);
      chk("user state", 4, rd[2:0]);
      chk("words loaded", 3, rd[19:16]);
      chk("done_oe stays", 0, d_oe);
      chk("ready_oe stays", 0, r_oe);
      apb(0, `CSH_OFF_ISTAT, 0);
      chk("istat good", 3'b101, rd[3:1]);
      foreach (words[i]) begin
         apb(1, `CSH_OFF_RADDR, i);
         repeat (2) @(posedge clk);
         apb(0, `CSH_OFF_RDATA, 0);
         chk("memory word", words[i], rd);
      end
      $display("test good load done");

      // reset in mid-run must drive both pins and wipe the memory
      rst_b <= 1'b0;
      repeat (2) @(negedge clk);
      chk("ready_oe reset", 1, r_oe);
      chk("done_oe reset", 1, d_oe);
      @(posedge clk);
      rst_b <= 1'b1;
      wait_ready();
      apb(1, `CSH_OFF_RADDR, 0);
      repeat (2) @(posedge clk);
      apb(0, `CSH_OFF_RDATA, 0);
      chk("memory cleared", 0, rd);
      $display("test mid reset done");

      reinit(4'ha);
      load(2, 1'b1);
      apb(0, `CSH_OFF_STAT, 0);
      chk("error state", 5, rd[2:0]);
      chk("done_oe error", 1, d_oe);
      chk("ready_oe error", 1, r_oe);
      chk("pin data low", 0, {r_o, d_o});
      apb(0, `CSH_OFF_ISTAT, 0);
      chk("istat error", 3'b010, rd[3:1]);
      $display("test bad load done");
      final_report();
   end
endmodule : csh_top_test
`default_nettype wire
